// file: design/cbd_consts.vh
`ifndef CBD_CONSTS_VH
`define CBD_CONSTS_VH
// operation field codes, first four bits of the instruction word
`define CBD_OP_NOP 4'h0
`define CBD_OP_SYS 4'h1
`define CBD_OP_LDC 4'h2
`define CBD_OP_STC 4'h3
`define CBD_OP_CONTROL_AND_INSTR 4'h4
`define CBD_OP_ORC 4'h5
`define CBD_OP_CONTROL_XOR_INSTR 4'h6
`define CBD_OP_BLK 4'h7
`define CBD_OP_ARITH 4'h8
`define CBD_OP_XFER 4'h9
`define CBD_OP_BITI 4'hA
`define CBD_OP_BRA 4'hB
`define CBD_OP_BITR 4'hC
// second operation field of system group
`define CBD_SYS_TRAP 4'h0
`define CBD_SYS_RTE 4'h1
`define CBD_SYS_SLEEP 4'h2
// field positions
`define CBD_OP_HI 15
`define CBD_OP_LO 12
`define CBD_MODE_HI 11
`define CBD_MODE_LO 9
`define CBD_SIZE_HI 8
`define CBD_SIZE_LO 7
`define CBD_RA_HI 6
`define CBD_RA_LO 4
`define CBD_RD_HI 3
`define CBD_RD_LO 0
`define CBD_TGT_BIT 11
`define CBD_LSZ_BIT 10
`define CBD_WIDE_BIT 8
// addressing modes
`define CBD_AM_RDIR 3'h0
`define CBD_AM_RIND 3'h1
`define CBD_AM_DISP 3'h2
`define CBD_AM_INCDEC 3'h3
`define CBD_AM_ABS 3'h4
`define CBD_AM_IMM 3'h5
`define CBD_AM_PCREL 3'h6
`define CBD_AM_MIND 3'h7
// operand sizes
`define CBD_SZ_B 2'h0
`define CBD_SZ_W 2'h1
`define CBD_SZ_L 2'h2
// register-direct part select
`define CBD_PART_BH 3'h0
`define CBD_PART_BL 3'h1
`define CBD_PART_WR 3'h2
`define CBD_PART_WE 3'h3
`define CBD_PART_L 3'h4
// extension length codes
`define CBD_EXT_NONE 2'h0
`define CBD_EXT_8 2'h1
`define CBD_EXT_16 2'h2
`define CBD_EXT_32 2'h3
// pointer steps, pc step per 2-byte unit
`define CBD_STEP_B 3'h1
`define CBD_STEP_W 3'h2
`define CBD_STEP_L 3'h4
`define CBD_PC_UNIT 24'h000002
// reset values
`define CBD_PC_RST 24'h000000
`define CBD_CCR_RST 8'h80
`define CBD_EXR_RST 8'h07
`endif

// file: design/cbd_decode.v
`timescale 1ns/1ps
`include "cbd_consts.vh"
module cbd_decode (
   input wire clk,
   input wire rst_b,
   input wire clk_en,
   input wire instr_valid,
   output wire instr_ready,
   input wire [15:0] instr_word,
   input wire [31:0] instr_ext,
   input wire [15:0] src_operand,
   input wire wake,
   input wire [31:0] source_pointer_reg,
   input wire [31:0] destination_pointer_reg,
   input wire [15:0] word_count_reg,
   output reg dec_valid_q,
   output reg illegal_q,
   output reg [3:0] opcode_q,
   output reg [2:0] mode_q,
   output reg [1:0] size_q,
   output reg [2:0] reg_addr_q,
   output reg [3:0] reg_data_q,
   output reg [2:0] reg_part_q,
   output reg [1:0] reg_count_q,
   output reg [1:0] ext_len_q,
   output reg [31:0] ext_data_q,
   output reg [2:0] step_q,
   output reg [3:0] cond_q,
   output reg [2:0] bit_num_q,
   output reg bit_from_reg_q,
   output reg [23:0] pc_q,
   output reg trap_q,
   output reg [1:0] trap_vec_q,
   output reg exc_return_q,
   output reg in_exception_q,
   output reg sleep_q,
   output reg [7:0] condition_code_register_q,
   output reg [7:0] extended_control_register_q,
   output reg store_q,
   output reg [15:0] store_data_q,
   output reg mem_req_q,
   output reg mem_we_q,
   output reg [31:0] mem_addr_q,
   output reg [7:0] mem_wdata_q,
   input wire mem_ack,
   input wire [7:0] mem_rdata,
   output reg [31:0] src_ptr_q,
   output reg [31:0] dst_ptr_q,
   output reg [15:0] count_q,
   output reg blk_wb_q
);

localparam ST_IDLE = 2'h0;
localparam ST_READ = 2'h1;
localparam ST_WRITE = 2'h2;

reg [1:0] st_q;
reg blk_word_q;
reg [1:0] units;
reg legal;
reg [1:0] nreg;
reg [1:0] ext;
reg [2:0] part;
reg [2:0] step;

wire [3:0] op = instr_word[`CBD_OP_HI:`CBD_OP_LO];
wire [3:0] op2 = instr_word[11:8];
wire [2:0] md = instr_word[`CBD_MODE_HI:`CBD_MODE_LO];
wire [1:0] sz = instr_word[`CBD_SIZE_HI:`CBD_SIZE_LO];
wire [2:0] ra = instr_word[`CBD_RA_HI:`CBD_RA_LO];
wire [3:0] rd = instr_word[`CBD_RD_HI:`CBD_RD_LO];
wire tgt_exr = instr_word[`CBD_TGT_BIT];
wire lsz_w = instr_word[`CBD_LSZ_BIT];
wire busy = (st_q != ST_IDLE);
wire take = instr_valid & instr_ready & clk_en;
wire [15:0] cnt_dec = count_q - 16'h0001;
wire cnt_last = blk_word_q ? (cnt_dec == 16'h0000) : (cnt_dec[7:0] == 8'h00);

// next instruction waits for block move end and wake from sleep
assign instr_ready = ~busy & ~sleep_q;

////////////////////////////////////////////////////////////////////////////////
// field decode

always @*
begin
   legal = 1'b1;
   nreg = 2'h0;
   ext = `CBD_EXT_NONE;
   // eight modes, extension by mode and size
   case (md)
      `CBD_AM_DISP: ext = (sz == `CBD_SZ_L) ? `CBD_EXT_32 : `CBD_EXT_16;
      `CBD_AM_ABS, `CBD_AM_IMM:
      begin
         case (sz)
            `CBD_SZ_B: ext = `CBD_EXT_8;
            `CBD_SZ_W: ext = `CBD_EXT_16;
            default: ext = `CBD_EXT_32;
         endcase
      end
      `CBD_AM_PCREL: ext = (sz == `CBD_SZ_B) ? `CBD_EXT_8 : `CBD_EXT_16;
      `CBD_AM_MIND: ext = `CBD_EXT_8;
      default: ext = `CBD_EXT_NONE;
   endcase
   // operand count and mode legality per class
   case (op)
      `CBD_OP_NOP, `CBD_OP_BLK, `CBD_OP_CONTROL_AND_INSTR, `CBD_OP_ORC, `CBD_OP_CONTROL_XOR_INSTR:
         ext = `CBD_EXT_NONE;
      `CBD_OP_SYS:
      begin
         ext = `CBD_EXT_NONE;
         legal = (op2 == `CBD_SYS_TRAP) | (op2 == `CBD_SYS_RTE) |
                 (op2 == `CBD_SYS_SLEEP);
      end
      `CBD_OP_ARITH:
      begin
         nreg = 2'h2;
         legal = (md == `CBD_AM_RDIR) | (md == `CBD_AM_IMM);
      end
      `CBD_OP_XFER:
      begin
         nreg = 2'h2;
         legal = (md != `CBD_AM_PCREL) & (md != `CBD_AM_MIND);
      end
      `CBD_OP_LDC, `CBD_OP_STC:
      begin
         nreg = (md == `CBD_AM_IMM) | (md == `CBD_AM_ABS) ? 2'h0 : 2'h1;
         // [11:10] carry target and size here, so the mode field is not checked
         legal = ~instr_word[8];
      end
      `CBD_OP_BITI, `CBD_OP_BITR:
      begin
         nreg = (op == `CBD_OP_BITR) ? 2'h2 : 2'h1;
         if (md == `CBD_AM_ABS)
         begin
            nreg = nreg - 2'h1;
            ext = `CBD_EXT_8;
         end
         legal = (md == `CBD_AM_RDIR) | (md == `CBD_AM_RIND) |
                 (md == `CBD_AM_ABS);
      end
      `CBD_OP_BRA: ext = `CBD_EXT_8;
      default: legal = 1'b0;
   endcase
   // register-direct part select
   case (sz)
      `CBD_SZ_B: part = rd[3] ? `CBD_PART_BL : `CBD_PART_BH;
      `CBD_SZ_W: part = rd[3] ? `CBD_PART_WE : `CBD_PART_WR;
      default: part = `CBD_PART_L;
   endcase
   // post-increment / pre-decrement step
   case (sz)
      `CBD_SZ_B: step = `CBD_STEP_B;
      `CBD_SZ_W: step = `CBD_STEP_W;
      default: step = `CBD_STEP_L;
   endcase
   // instruction length in 2-byte units beyond the first
   case (ext)
      `CBD_EXT_32: units = 2'h2;
      `CBD_EXT_NONE: units = 2'h0;
      default: units = 2'h1;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// decode outputs, pc, control registers, system control

always @(posedge clk)
begin
   if (!rst_b)
   begin
      dec_valid_q <= 1'b0;
      illegal_q <= 1'b0;
      opcode_q <= `CBD_OP_NOP;
      mode_q <= `CBD_AM_RDIR;
      size_q <= `CBD_SZ_B;
      reg_addr_q <= 3'h0;
      reg_data_q <= 4'h0;
      reg_part_q <= `CBD_PART_BH;
      reg_count_q <= 2'h0;
      ext_len_q <= `CBD_EXT_NONE;
      ext_data_q <= 32'h00000000;
      step_q <= 3'h0;
      cond_q <= 4'h0;
      bit_num_q <= 3'h0;
      bit_from_reg_q <= 1'b0;
      pc_q <= `CBD_PC_RST;
      trap_q <= 1'b0;
      trap_vec_q <= 2'h0;
      exc_return_q <= 1'b0;
      in_exception_q <= 1'b0;
      sleep_q <= 1'b0;
      condition_code_register_q <= `CBD_CCR_RST;
      extended_control_register_q <= `CBD_EXR_RST;
      store_q <= 1'b0;
      store_data_q <= 16'h0000;
   end
   else if (clk_en)
   begin
      dec_valid_q <= take;
      trap_q <= 1'b0;
      exc_return_q <= 1'b0;
      store_q <= 1'b0;
      if (sleep_q & wake)
         sleep_q <= 1'b0;
      if (take)
      begin
         illegal_q <= ~legal;
         opcode_q <= op;
         mode_q <= md;
         size_q <= sz;
         reg_addr_q <= ra;
         reg_data_q <= rd;
         reg_part_q <= part;
         reg_count_q <= nreg;
         ext_len_q <= ext;
         ext_data_q <= instr_ext;
         step_q <= (md == `CBD_AM_INCDEC) ? step : 3'h0;
         cond_q <= (op == `CBD_OP_BRA) ? op2 : 4'h0;
         bit_num_q <= ra;
         bit_from_reg_q <= (op == `CBD_OP_BITR);
         // pc moves by whole units; nop adds two only
         if (~((op == `CBD_OP_SYS) & legal & (op2 != `CBD_SYS_SLEEP)))
            pc_q <= pc_q + `CBD_PC_UNIT + {21'h000000, units, 1'b0};
         if (legal)
         begin
            case (op)
               `CBD_OP_SYS:
               begin
                  case (op2)
                     `CBD_SYS_TRAP:
                     begin
                        trap_q <= 1'b1;
                        trap_vec_q <= instr_word[1:0];
                        in_exception_q <= 1'b1;
                     end
                     `CBD_SYS_RTE:
                     begin
                        exc_return_q <= 1'b1;
                        in_exception_q <= 1'b0;
                     end
                     default: sleep_q <= 1'b1;
                  endcase
               end
               `CBD_OP_LDC:
               begin
                  // word form keeps the upper byte
                  if (tgt_exr)
                     extended_control_register_q <= lsz_w ? src_operand[15:8] :
                                                    src_operand[7:0];
                  else
                     condition_code_register_q <= lsz_w ? src_operand[15:8] :
                                                  src_operand[7:0];
               end
               `CBD_OP_STC:
               begin
                  store_q <= 1'b1;
                  if (lsz_w)
                     store_data_q <= {tgt_exr ? extended_control_register_q :
                                      condition_code_register_q, 8'h00};
                  else
                     store_data_q <= {8'h00, tgt_exr ? extended_control_register_q :
                                      condition_code_register_q};
               end
               `CBD_OP_CONTROL_AND_INSTR:
               begin
                  if (tgt_exr)
                     extended_control_register_q <=
                        extended_control_register_q & instr_word[7:0];
                  else
                     condition_code_register_q <=
                        condition_code_register_q & instr_word[7:0];
               end
               `CBD_OP_ORC:
               begin
                  if (tgt_exr)
                     extended_control_register_q <=
                        extended_control_register_q | instr_word[7:0];
                  else
                     condition_code_register_q <=
                        condition_code_register_q | instr_word[7:0];
               end
               `CBD_OP_CONTROL_XOR_INSTR:
               begin
                  if (tgt_exr)
                     extended_control_register_q <=
                        extended_control_register_q ^ instr_word[7:0];
                  else
                     condition_code_register_q <=
                        condition_code_register_q ^ instr_word[7:0];
               end
               default: ;
            endcase
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// block move engine

always @(posedge clk)
begin
   if (!rst_b)
   begin
      st_q <= ST_IDLE;
      blk_word_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 32'h00000000;
      mem_wdata_q <= 8'h00;
      src_ptr_q <= 32'h00000000;
      dst_ptr_q <= 32'h00000000;
      count_q <= 16'h0000;
      blk_wb_q <= 1'b0;
   end
   else if (clk_en)
   begin
      blk_wb_q <= 1'b0;
      case (st_q)
         ST_IDLE:
         begin
            if (take & (op == `CBD_OP_BLK))
            begin
               blk_word_q <= instr_word[`CBD_WIDE_BIT];
               src_ptr_q <= source_pointer_reg;
               dst_ptr_q <= destination_pointer_reg;
               count_q <= word_count_reg;
               // zero count moves nothing
               if (instr_word[`CBD_WIDE_BIT] ? (word_count_reg != 16'h0000) :
                   (word_count_reg[7:0] != 8'h00))
               begin
                  st_q <= ST_READ;
                  mem_req_q <= 1'b1;
                  mem_we_q <= 1'b0;
                  mem_addr_q <= source_pointer_reg;
               end
               else
                  blk_wb_q <= 1'b1;
            end
         end
         ST_READ:
         begin
            if (mem_ack)
            begin
               st_q <= ST_WRITE;
               mem_we_q <= 1'b1;
               mem_addr_q <= dst_ptr_q;
               mem_wdata_q <= mem_rdata;
            end
         end
         ST_WRITE:
         begin
            if (mem_ack)
            begin
               // post-increment both pointers, count down
               src_ptr_q <= src_ptr_q + 32'h00000001;
               dst_ptr_q <= dst_ptr_q + 32'h00000001;
               if (blk_word_q)
                  count_q <= cnt_dec;
               else
                  count_q <= {count_q[15:8], cnt_dec[7:0]};
               mem_we_q <= 1'b0;
               if (cnt_last)
               begin
                  st_q <= ST_IDLE;
                  mem_req_q <= 1'b0;
                  blk_wb_q <= 1'b1;
               end
               else
               begin
                  st_q <= ST_READ;
                  mem_addr_q <= src_ptr_q + 32'h00000001;
               end
            end
         end
         default:
         begin
            st_q <= ST_IDLE;
            mem_req_q <= 1'b0;
         end
      endcase
   end
end

endmodule // cbd_decode

// file: verification/cbd_decode_props.sv
`timescale 1ns/1ps
module cbd_decode_props (
   input wire clk,
   input wire rst_b,
   input wire clk_en,
   input wire instr_valid,
   input wire instr_ready,
   input wire [15:0] instr_word,
   input wire [15:0] word_count_reg,
   input wire dec_valid_q,
   input wire [2:0] step_q,
   input wire [23:0] pc_q,
   input wire trap_q,
   input wire sleep_q,
   input wire [7:0] condition_code_register_q,
   input wire mem_req_q,
   input wire mem_we_q,
   input wire [31:0] mem_addr_q,
   input wire mem_ack,
   input wire blk_wb_q
);
   wire acc = instr_valid && instr_ready && clk_en;
   wire [7:0] imm = instr_word[7:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   sequence rd_ack_s;
      mem_req_q && !mem_we_q && mem_ack;
   endsequence
   sequence wr_s;
      mem_req_q && mem_we_q;
   endsequence
   dec_pulse_a: assert property (acc |=> dec_valid_q)
      else $error("no decode pulse after accept");
   dec_quiet_a: assert property (clk_en && !acc |=> !dec_valid_q)
      else $error("decode pulse without accept");
   nop_pc_a: assert property (acc && instr_word == 16'h0000 |=> pc_q == $past(pc_q) + 24'h000002)
      else $error("no-op did not step pc by two");
   trap_start_a: assert property (acc && instr_word[15:8] == 8'h10 |=> trap_q && $stable(pc_q))
      else $error("trap not started");
   sleep_halt_a: assert property (sleep_q |-> !instr_ready)
      else $error("instruction taken while asleep");
   ctl_and_a: assert property (acc && instr_word[15:11] == 5'h08 |=>
      condition_code_register_q == ($past(condition_code_register_q) & $past(imm)))
      else $error("control and result wrong");
   byte_step_a: assert property (acc && instr_word[15:7] == 9'h12C |=> step_q == 3'h1)
      else $error("byte step not one");
   blk_zero_a: assert property (acc && instr_word[15:12] == 4'h7 && !instr_word[8]
      && word_count_reg[7:0] == 8'h00 |=> blk_wb_q && !mem_req_q)
      else $error("zero count block move not immediate");
   mem_hold_a: assert property (mem_req_q && !mem_ack |=>
      mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
      else $error("memory request changed before ack");
   rd_wr_a: assert property (rd_ack_s |=> wr_s)
      else $error("read not followed by write");
   blk_busy_a: assert property (mem_req_q |-> !instr_ready)
      else $error("instruction taken during block move");
endmodule // cbd_decode_props
bind cbd_decode cbd_decode_props u_props (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
   .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_word(instr_word),
   .word_count_reg(word_count_reg), .dec_valid_q(dec_valid_q), .step_q(step_q), .pc_q(pc_q),
   .trap_q(trap_q), .sleep_q(sleep_q), .condition_code_register_q(condition_code_register_q),
   .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
   .blk_wb_q(blk_wb_q));

// file: verification/cbd_mem_model.sv
`timescale 1ns/1ps
module cbd_mem_model (
   input wire clk,
   input wire rst_b,
   input wire slow,
   input wire mem_req,
   input wire mem_we,
   input wire [31:0] mem_addr,
   input wire [7:0] mem_wdata,
   output reg mem_ack,
   output reg [7:0] mem_rdata
);
   reg [7:0] mem [0:255];
   reg [7:0] lfsr_q = 8'h5A;
   reg [7:0] wait_q = 8'h00;
   initial mem_ack = 1'b0;
   initial mem_rdata = 8'h00;
   ////////////////////////////////////////////////////////////////////////////////
   // byte memory, one ack pulse per access, read data only valid with ack
   always @(posedge clk)
   begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (!rst_b)
         wait_q <= 8'h00;
      else if (mem_req && !mem_ack)
      begin
         if (wait_q == 8'h00)
         begin
            mem_ack <= 1'b1;
            wait_q <= slow ? {6'h00, lfsr_q[1:0]} : 8'h00;
            if (mem_we)
               mem[mem_addr[7:0]] <= mem_wdata;
            else
               mem_rdata <= mem[mem_addr[7:0]];
         end
         else
            wait_q <= wait_q - 8'h01;
      end
   end
endmodule // cbd_mem_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg clk, rst_b, clk_en, instr_valid, wake, slow;
   reg [15:0] instr_word, src_operand, word_count_reg, src_v, w;
   reg [31:0] instr_ext, source_pointer_reg, destination_pointer_reg, seed;
   reg [7:0] e_ccr, e_exr, buf_v [0:15];
   reg [3:0] op;
   reg [23:0] p;
   integer num_errors, checks, i, m;
   wire instr_ready, dec_valid_q, illegal_q, bit_from_reg_q, trap_q, exc_return_q, sleep_q;
   wire store_q, mem_req_q, mem_we_q, mem_ack, blk_wb_q;
   wire in_exception_q;
   wire [1:0] size_q, reg_count_q, ext_len_q;
   wire [2:0] mode_q, reg_addr_q, reg_part_q, step_q, bit_num_q;
   wire [3:0] reg_data_q, cond_q, opcode_q;
   wire [1:0] trap_vec_q;
   wire [23:0] pc_q;
   wire [7:0] condition_code_register_q, extended_control_register_q, mem_wdata_q, mem_rdata;
   wire [15:0] store_data_q, count_q;
   wire [31:0] mem_addr_q, src_ptr_q, dst_ptr_q, ext_data_q;
   cbd_decode dut (.*);
   cbd_mem_model mdl (.clk(clk), .rst_b(rst_b), .slow(slow), .mem_req(mem_req_q),
      .mem_we(mem_we_q), .mem_addr(mem_addr_q), .mem_wdata(mem_wdata_q), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [7:0] ctl(input [3:0] o, input [7:0] v, input [7:0] k);
      ctl = (o == 4'h4) ? (v & k) : (o == 4'h5) ? (v | k) : (v ^ k);
   endfunction
   function legal(input [3:0] o, input [2:0] md);
      legal = (o == 4'h8) ? (md == 3'h0 || md == 3'h5) : (o == 4'h9) ? (md < 3'h6)
         : (md == 3'h0 || md == 3'h1 || md == 3'h4);
   endfunction
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp)
         begin
            num_errors = num_errors + 1;
            $display("FAIL %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task issue(input [15:0] iw);
      integer n;
      begin
         n = 0;
         while (instr_ready !== 1'b1 && n < 500)
         begin
            @(negedge clk);
            n = n + 1;
         end
         @(posedge clk);
         instr_word <= iw;
         src_operand <= src_v;
         instr_ext <= seed;
         instr_valid <= 1'b1;
         @(posedge clk);
         instr_valid <= 1'b0;
         @(negedge clk);
      end
   endtask
   task blk(input [15:0] iw, input [15:0] cnt, input s);
      integer n, k;
      begin
         n = iw[8] ? cnt : cnt[7:0];
         for (k = 0; k < n; k = k + 1)
         begin
            seed = xs(seed);
            buf_v[k] = seed[7:0];
            mdl.mem[8'h10 + k] = seed[7:0];
         end
         @(posedge clk);
         slow <= s;
         source_pointer_reg <= 32'h00000010;
         destination_pointer_reg <= 32'h00000040;
         word_count_reg <= cnt;
         issue(iw);
         k = 0;
         while (blk_wb_q !== 1'b1 && k < 400)
         begin
            @(negedge clk);
            k = k + 1;
         end
         chk("blk_done", blk_wb_q, 1);
         chk("src_ptr", src_ptr_q, 32'h10 + n);
         chk("dst_ptr", dst_ptr_q, 32'h40 + n);
         chk("count", count_q, iw[8] ? 16'h0000 : {cnt[15:8], 8'h00});
         for (k = 0; k < n; k = k + 1)
            chk("dst_byte", mdl.mem[8'h40 + k], buf_v[k]);
         chk("ready", instr_ready, 1);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", checks, num_errors);
         if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors = num_errors + 1;
      finish_test;
   end
   initial
   begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      wake = 1'b0;
      slow = 1'b0;
      instr_word = 16'h0000;
      src_operand = 16'h0000;
      src_v = 16'h0000;
      word_count_reg = 16'h0000;
      instr_ext = 32'h00000000;
      source_pointer_reg = 32'h00000000;
      destination_pointer_reg = 32'h00000000;
      seed = 32'h9dfa;
      num_errors = 0;
      checks = 0;
      e_ccr = 8'h80;
      e_exr = 8'h07;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("pc_rst", pc_q, 0);
      chk("ccr_rst", condition_code_register_q, e_ccr);
      chk("exr_rst", extended_control_register_q, e_exr);
      p = pc_q;
      issue(16'h0000);
      chk("nop_pc", pc_q, p + 24'h000002);
      chk("nop_dec", dec_valid_q, 1);
      $display("test basic done");
      for (i = 0; i < 6; i = i + 1)
      begin
         seed = xs(seed);
         op = 4'h4 + i / 2;
         issue({op, i[0], 3'h0, seed[7:0]});
         if (i[0])
            e_exr = ctl(op, e_exr, seed[7:0]);
         else
            e_ccr = ctl(op, e_ccr, seed[7:0]);
         chk("ccr", condition_code_register_q, e_ccr);
         chk("exr", extended_control_register_q, e_exr);
      end
      seed = xs(seed);
      src_v = seed[15:0];
      issue(16'h2000);
      chk("ldc_b", condition_code_register_q, src_v[7:0]);
      issue(16'h2C00);
      chk("ldc_w", extended_control_register_q, src_v[15:8]);
      issue(16'h3000);
      chk("stc_b", store_data_q, {8'h00, src_v[7:0]});
      chk("stc_q", store_q, 1);
      issue(16'h3C00);
      chk("stc_w", store_data_q, {src_v[15:8], 8'h00});
      $display("test control done");
      p = pc_q;
      issue(16'h1002);
      chk("trap", trap_q, 1);
      chk("trap_vec", trap_vec_q, 2);
      chk("trap_pc", pc_q, p);
      chk("in_exc", in_exception_q, 1);
      issue(16'h1100);
      chk("rte", exc_return_q, 1);
      chk("out_exc", in_exception_q, 0);
      issue(16'h1200);
      chk("sleep", sleep_q, 1);
      chk("sleep_rdy", instr_ready, 0);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(negedge clk);
      chk("wake", sleep_q, 0);
      p = pc_q;
      @(posedge clk);
      clk_en <= 1'b0;
      instr_word <= 16'h0000;
      instr_valid <= 1'b1;
      repeat (3) @(posedge clk);
      clk_en <= 1'b1;
      instr_valid <= 1'b0;
      @(negedge clk);
      chk("frozen_pc", pc_q, p);
      $display("test system done");
      for (i = 0; i < 32; i = i + 1)
      begin
         seed = xs(seed);
         op = (i < 24) ? 4'h8 + i / 8 : 4'hC;
         issue({op, i[2:0], 2'h0, seed[6:0]});
         chk("illegal", illegal_q, !legal(op, i[2:0]));
         chk("mode", mode_q, i[2:0]);
         chk("opcode", opcode_q, op);
         chk("ext_len", ext_len_q, (i[2:0] == 3'h2) ? 2 : (i[2:0] >= 3'h4) ? 1 : 0);
         chk("ext_data", ext_data_q, seed);
         chk("reg_count", reg_count_q,
            ((op == 4'hA) ? 1 : 2) - (op >= 4'hA && i[2:0] == 3'h4));
         if (op >= 4'hA)
         begin
            chk("bit_src", bit_from_reg_q, op == 4'hC);
            chk("bit_num", bit_num_q, seed[6:4]);
         end
      end
      for (i = 0; i < 6; i = i + 1)
      begin
         seed = xs(seed);
         w = {4'h9, i[0] ? 3'h3 : 3'h0, 2'(i / 2), seed[6:0]};
         issue(w);
         chk("reg_addr", reg_addr_q, w[6:4]);
         chk("reg_data", reg_data_q, w[3:0]);
         chk("size", size_q, i / 2);
         m = (i / 2 == 0) ? 1 : (i / 2 == 1) ? 2 : 4;
         chk("step", step_q, i[0] ? m : 0);
         if (!i[0])
            chk("part", reg_part_q, (i / 2 == 2) ? 4 : {i[2:1], w[3]});
      end
      for (i = 0; i < 16; i = i + 1)
      begin
         seed = xs(seed);
         issue({4'hB, i[3:0], seed[7:0]});
         chk("cond", cond_q, i[3:0]);
      end
      $display("test modes done");
      blk(16'h7000, 16'hA503, 1'b1);
      blk(16'h7100, 16'h0005, 1'b0);
      blk(16'h7000, 16'h3400, 1'b0);
      blk(16'h7100, 16'h0000, 1'b1);
      $display("test block move done");
      finish_test;
   end
endmodule // tb_top
